/* File: logic/pmse_defines.vh */
// constants for the pm timer and general purpose event 0 status block
`ifndef PMSE_DEFINES_VH
`define PMSE_DEFINES_VH

// offsets inside the pm1 i/o block
`define PMSE_OFS_TMR_UPPER 4'hA
`define PMSE_OFS_TMR_SPARE 4'hB
// offsets inside the event 0 i/o block
`define PMSE_OFS_EV0_STS_LO 4'h0
`define PMSE_OFS_EV0_STS_HI 4'h1
`define PMSE_OFS_EV0_EN_LO 4'h2
`define PMSE_OFS_EV0_EN_HI 4'h3

// field layout
`define PMSE_TMR_W 24
`define PMSE_TMR_UPPER_LSB 16
`define PMSE_TMR_MSB 23
`define PMSE_EV_N 7
`define PMSE_EV_SERIAL2 0
`define PMSE_EV_SERIAL1 1
`define PMSE_EV_FLOPPY 2
`define PMSE_EV_PRINTER 3
`define PMSE_EV_KEYBOARD 4
`define PMSE_EV_MOUSE 5
`define PMSE_EV_INFRARED 6

// reset values
`define PMSE_RST_BYTE 8'h00
`define PMSE_RST_TMR 24'h000000
`define PMSE_RST_EV 7'h00

// timebase: tick rate in hz and core clock rate in hz
// sized to the accumulator so no constant is cut on assignment
`define PMSE_TB_HZ 28'h0369E99
`define PMSE_CORE_HZ 28'hEE6B280
`define PMSE_TB_ACC_W 28

`endif

/* File: logic/pmse_timebase.v */
// fractional divider giving one-cycle ticks at the pm timer rate
`timescale 1ns/1ps
`include "pmse_defines.vh"

module pmse_timebase
(
  input wire core_clk,
  input wire nrst,
  input wire run,
  output reg tick_q
);

  localparam [`PMSE_TB_ACC_W-1:0] INC = `PMSE_TB_HZ;
  localparam [`PMSE_TB_ACC_W-1:0] MODV = `PMSE_CORE_HZ;

  reg [`PMSE_TB_ACC_W-1:0] acc_q;
  reg [`PMSE_TB_ACC_W-1:0] acc_d;
  reg tick_d;

  // phase accumulator: average rate is exact, jitter is one core cycle
  always @*
  begin
    acc_d = acc_q;
    tick_d = 1'b0;
    if (run)
    begin
      if (acc_q >= MODV - INC)
      begin
        acc_d = acc_q - (MODV - INC);
        tick_d = 1'b1;
      end
      else
      begin
        acc_d = acc_q + INC;
      end
    end
  end

  // phase is held while stopped so the rate picks up where it left
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      acc_q <= {`PMSE_TB_ACC_W{1'b0}};
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

endmodule

/* File: logic/pmse_top.v */
// pm timer upper byte, timer flag and event 0 status with interrupt pin
`timescale 1ns/1ps
`include "pmse_defines.vh"

module pmse_top
(
  input wire core_clk,
  input wire nrst,
  input wire [15:0] pm1_base,
  input wire [15:0] ev0_base,
  input wire [15:0] io_addr,
  input wire io_rd,
  input wire io_wr,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata_q,
  output reg io_rvalid_q,
  input wire working_state,
  input wire chip_input_clock_run,
  input wire timer_irq_enable,
  input wire timer_wrap_clear,
  output reg timer_wrap_flag_q,
  input wire [6:0] periph_irq,
  output reg system_control_interrupt_n_q,
  output wire [23:0] timer_count_value
);

  ////////////////////////////////////////////////////////////////////////
  // address decode

  wire pm1_hit;
  wire ev0_hit;
  wire [3:0] ofs;
  wire [15:0] pm1_diff;
  wire [15:0] ev0_diff;

  assign pm1_diff = io_addr - pm1_base;
  assign ev0_diff = io_addr - ev0_base;
  // pm1 block spans 16 bytes, event 0 block spans 4
  assign pm1_hit = (pm1_diff[15:4] == 12'h000);
  assign ev0_hit = (ev0_diff[15:2] == 14'h0000);
  assign ofs = pm1_hit ? pm1_diff[3:0] : ev0_diff[3:0];

  wire wr_sts_lo;
  wire wr_en_lo;

  assign wr_sts_lo = io_wr && ev0_hit &&
    (ev0_diff[3:0] == `PMSE_OFS_EV0_STS_LO);
  assign wr_en_lo = io_wr && ev0_hit &&
    (ev0_diff[3:0] == `PMSE_OFS_EV0_EN_LO);

  ////////////////////////////////////////////////////////////////////////
  // timer

  wire tick;
  reg [`PMSE_TMR_W-1:0] tmr_q;
  reg [`PMSE_TMR_W-1:0] tmr_d;
  reg msb_prev_q;

  // divider only advances while the input clock runs and system works
  pmse_timebase u_tb
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .run(chip_input_clock_run && working_state),
    .tick_q(tick)
  );

  // count has no write path at all, so host writes cannot disturb it
  always @*
  begin
    tmr_d = tmr_q;
    if (tick)
      tmr_d = tmr_q + 24'h000001;
  end

  // stopped clock freezes the count; only master reset clears it
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      tmr_q <= `PMSE_RST_TMR;
      msb_prev_q <= 1'b0;
    end
    else
    begin
      tmr_q <= tmr_d;
      msb_prev_q <= tmr_q[`PMSE_TMR_MSB];
    end
  end

  assign timer_count_value = tmr_q;

  wire msb_flip;
  assign msb_flip = tmr_q[`PMSE_TMR_MSB] ^ msb_prev_q;

  // timer flag: set wins over a clear in the same cycle
  always @(posedge core_clk)
  begin
    if (!nrst)
      timer_wrap_flag_q <= 1'b0;
    else if (msb_flip)
      timer_wrap_flag_q <= 1'b1;
    else if (timer_wrap_clear)
      timer_wrap_flag_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // event 0 status and enable

  reg [6:0] ev_sts_q;
  reg [6:0] ev_en_q;
  reg [6:0] irq_prev_q;
  wire [6:0] ev_set;

  // enable byte; bit 7 is reserved and not stored
  always @(posedge core_clk)
  begin
    if (!nrst)
      ev_en_q <= `PMSE_RST_EV;
    else if (wr_en_lo)
      ev_en_q <= io_wdata[6:0];
  end

  // previous request levels for edge detection
  always @(posedge core_clk)
  begin
    if (!nrst)
      irq_prev_q <= `PMSE_RST_EV;
    else
      irq_prev_q <= periph_irq;
  end

  // one sticky bit per peripheral source
  genvar gi;
  generate
    for (gi = 0; gi < `PMSE_EV_N; gi = gi + 1)
    begin : g_ev
      // a held request must not refire after clear, hence edge only
      assign ev_set[gi] = periph_irq[gi] && !irq_prev_q[gi];
      always @(posedge core_clk)
      begin
        if (!nrst)
          ev_sts_q[gi] <= 1'b0;
        else if (ev_set[gi])
          ev_sts_q[gi] <= 1'b1;
        else if (wr_sts_lo && io_wdata[gi])
          ev_sts_q[gi] <= 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // interrupt pin, active low, registered to avoid glitches

  wire ev_irq;
  wire tmr_irq;
  assign ev_irq = |(ev_sts_q & ev_en_q);
  assign tmr_irq = timer_wrap_flag_q && timer_irq_enable;

  always @(posedge core_clk)
  begin
    if (!nrst)
      system_control_interrupt_n_q <= 1'b1;
    else
      system_control_interrupt_n_q <= !(ev_irq || tmr_irq);
  end

  ////////////////////////////////////////////////////////////////////////
  // read path, data one cycle after the read strobe

  reg [7:0] rd_d;

  always @*
  begin
    rd_d = `PMSE_RST_BYTE;
    if (pm1_hit)
    begin
      case (ofs)
        `PMSE_OFS_TMR_UPPER: rd_d =
          tmr_q[`PMSE_TMR_MSB:`PMSE_TMR_UPPER_LSB];
        `PMSE_OFS_TMR_SPARE: rd_d = `PMSE_RST_BYTE;
        default: rd_d = `PMSE_RST_BYTE;
      endcase
    end
    else if (ev0_hit)
    begin
      case (ofs)
        `PMSE_OFS_EV0_STS_LO: rd_d = {1'b0, ev_sts_q};
        `PMSE_OFS_EV0_STS_HI: rd_d = `PMSE_RST_BYTE;
        `PMSE_OFS_EV0_EN_LO: rd_d = {1'b0, ev_en_q};
        default: rd_d = `PMSE_RST_BYTE;
      endcase
    end
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      io_rdata_q <= `PMSE_RST_BYTE;
      io_rvalid_q <= 1'b0;
    end
    else
    begin
      io_rvalid_q <= io_rd;
      if (io_rd)
        io_rdata_q <= rd_d;
    end
  end

endmodule

/* File: testbench/pmse_sva.sv */
// port assertions for the pm timer and event 0 status block
`timescale 1ns/1ps
module pmse_sva
(
  input logic core_clk,
  input logic nrst,
  input logic [15:0] pm1_base,
  input logic [15:0] ev0_base,
  input logic [15:0] io_addr,
  input logic io_rd,
  input logic [7:0] io_rdata_q,
  input logic io_rvalid_q,
  input logic working_state,
  input logic chip_input_clock_run,
  input logic timer_irq_enable,
  input logic timer_wrap_clear,
  input logic timer_wrap_flag_q,
  input logic system_control_interrupt_n_q,
  input logic [23:0] timer_count_value
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // reads answer next cycle; timer byte is the top of the count
  a_read_valid: assert property (io_rd |=> io_rvalid_q)
    else $error("read not answered");
  a_timer_read: assert property (
    io_rd && io_addr == pm1_base + 16'h000A |=>
    {16'h0000, io_rdata_q} == $past(timer_count_value) >> 16)
    else $error("timer byte wrong");
  a_rsvd_zero: assert property (
    io_rd && (io_addr == pm1_base + 16'h000B ||
    io_addr == ev0_base + 16'h0001) |=> io_rdata_q == 8'h00)
    else $error("reserved byte not zero");
  // count only steps by one, and stands still while stopped
  a_count_step: assert property (
    $past(nrst) && $changed(timer_count_value) |->
    timer_count_value == $past(timer_count_value) + 24'h000001)
    else $error("count jumped");
  a_count_frozen: assert property (
    !(chip_input_clock_run && working_state) [*2] |=>
    $stable(timer_count_value))
    else $error("count moved while stopped");
  // the top bit sets the flag; otherwise it only holds or clears
  a_flag_rise: assert property (
    $past(nrst) && $changed(timer_count_value[23]) |=> timer_wrap_flag_q)
    else $error("flag missed");
  a_flag_hold: assert property (
    $past(nrst) && $stable(timer_count_value[23]) |=> timer_wrap_flag_q ==
    ($past(timer_wrap_flag_q) && !$past(timer_wrap_clear)))
    else $error("flag changed alone");
  a_timer_pin: assert property (
    timer_wrap_flag_q && timer_irq_enable |=> !system_control_interrupt_n_q)
    else $error("pin not low");
endmodule
bind pmse_top pmse_sva u_sva (.*);

/* File: testbench/pmse_host.sv */
// host model issuing one-byte i/o cycles to the block
`timescale 1ns/1ps
module pmse_host
(
  input logic core_clk,
  output logic [15:0] io_addr,
  output logic io_rd,
  output logic io_wr,
  output logic [7:0] io_wdata,
  input logic [7:0] io_rdata_q,
  input logic io_rvalid_q
);
  // idle bus; released lines carry inverted junk, not the old value
  initial
  begin
    io_addr = 16'h0000;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'h00;
  end
  task automatic wr(logic [15:0] a, logic [7:0] x);
    @(posedge core_clk);
    io_addr <= a;
    io_wdata <= x;
    io_wr <= 1'b1;
    @(posedge core_clk);
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~x;
  endtask
  task automatic rd(logic [15:0] a, output logic [7:0] x, output logic ok);
    @(posedge core_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge core_clk);
    io_rd <= 1'b0;
    io_addr <= ~a;
    @(posedge core_clk);
    x = io_rdata_q;
    ok = io_rvalid_q;
  endtask
endmodule

/* File: testbench/pmse_top_tb.sv */
// bench for the pm timer and event 0 status block
`timescale 1ns/1ps
module pmse_top_tb;
  logic core_clk = 0, nrst = 0, working_state = 1, timer_wrap_clear = 0;
  logic chip_input_clock_run = 1, timer_irq_enable = 1, v;
  logic io_rd, io_wr, io_rvalid_q, timer_wrap_flag_q;
  logic system_control_interrupt_n_q;
  logic [15:0] io_addr, pm1_base = 16'h0400, ev0_base = 16'h0420;
  logic [7:0] io_wdata, io_rdata_q, d;
  logic [6:0] periph_irq = 7'h00;
  logic [23:0] timer_count_value, t;
  int err_count = 0, tests_run = 0, cyc = 0;
  pmse_top DUT (.*);
  pmse_host host (.*);
  ////////////////////////////////////////
  // clock, and a hang guard well past the ~8.5k cycles of the run
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(logic [15:0] a, logic [7:0] e);
    host.rd(a, d, v);
    chk("rvalid", 1, v);
    chk("rdata", e, d);
  endtask
  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // registers, then each source set, ignored while set, cleared
  initial
  begin
    repeat (8) @(posedge core_clk);
    nrst <= 1;
    rdc(16'h0420, 8'h00);
    rdc(16'h040B, 8'h00);
    rdc(16'h0300, 8'h00);
    host.wr(16'h0421, 8'hFF);
    rdc(16'h0421, 8'h00);
    host.wr(16'h0422, 8'hFF);
    rdc(16'h0422, 8'h7F);
    for (int k = 0; k < 7; k++)
    begin
      periph_irq[k] <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("pin", 0, system_control_interrupt_n_q);
      rdc(16'h0420, 8'h01 << k);
      host.wr(16'h0420, ~(8'h01 << k));
      periph_irq[k] <= 1'b0;
      rdc(16'h0420, 8'h01 << k);
      periph_irq[k] <= 1'b1;
      host.wr(16'h0420, 8'h01 << k);
      rdc(16'h0420, 8'h00);
      chk("pin", 1, system_control_interrupt_n_q);
      periph_irq[k] <= 1'b0;
    end
    host.wr(16'h0422, 8'h7E);
    periph_irq[0] <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("pin", 1, system_control_interrupt_n_q);
    rdc(16'h0420, 8'h01);
    // timer: stop, reset, rate, idle, resume without clearing
    chip_input_clock_run <= 0;
    repeat (2) @(posedge core_clk);
    t = timer_count_value;
    host.wr(16'h040A, 8'hFF);
    repeat (300) @(posedge core_clk);
    chk("frozen", t, timer_count_value);
    rdc(16'h040A, 8'h00);
    chip_input_clock_run <= 1;
    nrst <= 0;
    repeat (8) @(posedge core_clk);
    chk("cleared", 0, timer_count_value);
    nrst <= 1;
    repeat (7000) @(posedge core_clk);
    t = timer_count_value;
    chk("rate", 1, t - 24'h000063 <= 24'h000002);
    working_state <= 0;
    repeat (2) @(posedge core_clk);
    t = timer_count_value;
    repeat (300) @(posedge core_clk);
    chk("idle", t, timer_count_value);
    working_state <= 1;
    repeat (700) @(posedge core_clk);
    t = timer_count_value - t - 24'h000009;
    chk("resume", 1, t <= 24'h000002);
    timer_wrap_clear <= 1;
    @(posedge core_clk);
    timer_wrap_clear <= 0;
    chk("flag", 0, timer_wrap_flag_q);
    end_of_test();
  end
endmodule
